// file: sola_pkg.sv
package sola_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int DATA_W   = 32;
  localparam int HALF_W   = 16;
  localparam int LINE_W   = 13;
  localparam int ADDR_W   = 7;
  localparam int PLANES   = 2;
  localparam int NFIELD   = 7;
  localparam int STRB_W   = DATA_W / 8;

  // ----------------------------------------------------------------
  // address map: addr[6:5] picks a group, addr[4:2] a word in it
  // ----------------------------------------------------------------
  localparam logic [1:0] GRP_COMMON = 2'h0;
  localparam logic [1:0] GRP_LUMA   = 2'h1;
  localparam logic [1:0] GRP_CHROMA = 2'h2;
  localparam int         GRP_LSB    = 5;
  localparam int         FLD_LSB    = 2;

  localparam logic [2:0] C_CTRL        = 3'h0;
  localparam logic [2:0] C_STAT_LUMA   = 3'h1;
  localparam logic [2:0] C_STAT_CHROMA = 3'h2;

  localparam logic [2:0] F_BASE_HI  = 3'h0;
  localparam logic [2:0] F_BASE_LO  = 3'h1;
  localparam logic [2:0] F_START_HI = 3'h2;
  localparam logic [2:0] F_START_LO = 3'h3;
  localparam logic [2:0] F_PITCH    = 3'h4;
  localparam logic [2:0] F_SPTR     = 3'h5;
  localparam logic [2:0] F_ELIM     = 3'h6;

  // ----------------------------------------------------------------
  // field masks and reset values, by field index
  // ----------------------------------------------------------------
  localparam logic [HALF_W-1:0] PITCH_MASK = 16'hffe0;
  localparam logic [HALF_W-1:0] LINE_MASK  = 16'h1fff;
  localparam logic [HALF_W-1:0] FULL_MASK  = 16'hffff;
  localparam logic [HALF_W-1:0] ZERO_HALF  = 16'h0000;
  localparam logic [HALF_W-1:0] ELIM_RESET = 16'h1fff;

  localparam logic [HALF_W-1:0] FIELD_MASK [NFIELD] = '{
    FULL_MASK, FULL_MASK, FULL_MASK, FULL_MASK, PITCH_MASK, LINE_MASK, LINE_MASK};
  localparam logic [HALF_W-1:0] FIELD_RESET [NFIELD] = '{
    ZERO_HALF, ZERO_HALF, ZERO_HALF, ZERO_HALF, ZERO_HALF, ZERO_HALF, ELIM_RESET};

  // ----------------------------------------------------------------
  // control and status bits
  // ----------------------------------------------------------------
  localparam int CTRL_RGB_BIT     = 0;
  localparam int STAT_IDX_LSB     = 0;
  localparam int STAT_MISUSE_BIT  = 16;
  localparam int STAT_RGBALN_BIT  = 17;
  localparam int STAT_WRAP_BIT    = 18;
  localparam logic [1:0] RGB_ALIGN_MASK = 2'h3;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // per-plane configuration as seen by the address walker
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [DATA_W-1:0] start_addr;
    logic [HALF_W-1:0] pitch;
    logic [LINE_W-1:0] start_ptr;
    logic [LINE_W-1:0] end_limit;
    logic              rgb_mode;
  } sola_plane_cfg_t;

endpackage : sola_pkg

// file: sola_plane_walker.sv
`timescale 1ns/1ps

module sola_plane_walker
  import sola_pkg::*;
#(
  parameter logic [HALF_W-1:0] RGB_PITCH = 16'h0800
) (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire sola_plane_cfg_t       cfg,
  input  wire logic                  frame_start,
  input  wire logic                  line_done,
  output logic        [DATA_W-1:0]   line_addr,
  output logic        [LINE_W-1:0]   line_index,
  output logic                       wrap_pulse
);

  // ----------------------------------------------------------------
  // line index and address
  // ----------------------------------------------------------------
  logic [LINE_W-1:0] next_line_index;
  logic [DATA_W-1:0] next_line_addr;
  logic              next_wrap_pulse;
  logic [HALF_W-1:0] eff_pitch;
  logic [DATA_W-1:0] offset;

  always_comb begin
    next_line_index = line_index;
    next_wrap_pulse = 1'b0;
    if (frame_start) begin
      next_line_index = cfg.start_ptr;
    end else if (line_done) begin
      if (line_index >= cfg.end_limit) begin
        next_line_index = '0;
        next_wrap_pulse = 1'b1;
      end else begin
        next_line_index = LINE_W'(line_index + 1'b1);
      end
    end
    // rgb lines have a fixed size, so the programmed pitch has no say
    if (cfg.rgb_mode) begin
      eff_pitch = RGB_PITCH;
    end else begin
      eff_pitch = cfg.pitch & PITCH_MASK;
    end
    offset = DATA_W'(next_line_index) * DATA_W'(eff_pitch);
    next_line_addr = DATA_W'(cfg.start_addr + offset);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      line_index <= '0;
      line_addr  <= '0;
      wrap_pulse <= 1'b0;
    end else begin
      line_index <= next_line_index;
      line_addr  <= next_line_addr;
      wrap_pulse <= next_wrap_pulse;
    end
  end

endmodule : sola_plane_walker

// file: sola_line_addresser.sv
`timescale 1ns/1ps

// Summary of operation
// - line address is start address plus line index times byte pitch
// - in rgb output mode the programmed pitch is ignored
// - low five pitch bits are held zero, pitch is a 32-byte multiple
// - a 13-bit start line pointer gives the first line position
// - a 13-bit end line limit, reset to all ones
// - past the end limit, addressing returns to the start address
// - a 16-bit field holds the upper half of the chroma base address
// - start address is built from upper and lower 16-bit halves
// - base address from two halves, compared against the start address
module sola_line_addresser
  import sola_pkg::*;
#(
  parameter logic [HALF_W-1:0] RGB_PITCH = 16'h0800
) (
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [DATA_W-1:0]   s_axi_wdata,
  input  wire logic [STRB_W-1:0]   s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic      [1:0]          s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic      [DATA_W-1:0]   s_axi_rdata,
  output logic      [1:0]          s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  input  wire logic                frame_start,
  input  wire logic                line_done,
  output logic      [DATA_W-1:0]   luma_line_addr,
  output logic      [DATA_W-1:0]   chroma_line_addr,
  output logic      [LINE_W-1:0]   luma_line_index,
  output logic      [LINE_W-1:0]   chroma_line_index
);

  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  logic [HALF_W-1:0] plane_reg      [PLANES][NFIELD];
  logic [HALF_W-1:0] next_plane_reg [PLANES][NFIELD];
  logic              rgb_mode;
  logic              next_rgb_mode;
  logic [PLANES-1:0] wrapped;
  logic [PLANES-1:0] next_wrapped;

  // ----------------------------------------------------------------
  // bus state
  // ----------------------------------------------------------------
  logic              aw_held;
  logic              next_aw_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [ADDR_W-1:0] next_aw_addr;
  logic              w_held;
  logic              next_w_held;
  logic [DATA_W-1:0] w_data;
  logic [DATA_W-1:0] next_w_data;
  logic [STRB_W-1:0] w_strb;
  logic [STRB_W-1:0] next_w_strb;
  logic              next_awready;
  logic              next_wready;
  logic              next_bvalid;
  logic [1:0]        next_bresp;
  logic              next_arready;
  logic              next_rvalid;
  logic [DATA_W-1:0] next_rdata;
  logic [1:0]        next_rresp;

  // ----------------------------------------------------------------
  // walker side
  // ----------------------------------------------------------------
  sola_plane_cfg_t   cfg        [PLANES];
  logic [DATA_W-1:0] walk_addr  [PLANES];
  logic [LINE_W-1:0] walk_index [PLANES];
  logic [PLANES-1:0] wrap_pulse;
  logic [PLANES-1:0] misuse;
  logic [PLANES-1:0] rgb_misalign;

  genvar gp;
  generate
    for (gp = 0; gp < PLANES; gp++) begin : g_plane
      logic [DATA_W-1:0] base_addr;

      // both halves join into full addresses
      assign cfg[gp].start_addr = {plane_reg[gp][F_START_HI],
                                   plane_reg[gp][F_START_LO]};
      assign base_addr          = {plane_reg[gp][F_BASE_HI],
                                   plane_reg[gp][F_BASE_LO]};
      assign cfg[gp].pitch      = plane_reg[gp][F_PITCH];
      assign cfg[gp].start_ptr  = plane_reg[gp][F_SPTR][LINE_W-1:0];
      assign cfg[gp].end_limit  = plane_reg[gp][F_ELIM][LINE_W-1:0];
      assign cfg[gp].rgb_mode   = rgb_mode;

      // flags software slips: start address equal to base with a nonzero start pointer, and rgb pointer misalignment
      assign misuse[gp] = (cfg[gp].start_addr == base_addr) &&
                          (cfg[gp].start_ptr != '0);
      assign rgb_misalign[gp] = rgb_mode &&
        (((cfg[gp].start_ptr[1:0] | cfg[gp].end_limit[1:0]) & RGB_ALIGN_MASK) != 2'h0);

      sola_plane_walker #(
        .RGB_PITCH   (RGB_PITCH)
      ) u_walker (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .cfg         (cfg[gp]),
        .frame_start (frame_start),
        .line_done   (line_done),
        .line_addr   (walk_addr[gp]),
        .line_index  (walk_index[gp]),
        .wrap_pulse  (wrap_pulse[gp])
      );
    end
  endgenerate

  assign luma_line_addr    = walk_addr[0];
  assign chroma_line_addr  = walk_addr[1];
  assign luma_line_index   = walk_index[0];
  assign chroma_line_index = walk_index[1];

  // ----------------------------------------------------------------
  // read data mux
  // ----------------------------------------------------------------
  function automatic logic [DATA_W-1:0] status_word(input int p);
    logic [DATA_W-1:0] s;
    s = '0;
    s[STAT_IDX_LSB +: LINE_W] = walk_index[p];
    s[STAT_MISUSE_BIT]        = misuse[p];
    s[STAT_RGBALN_BIT]        = rgb_misalign[p];
    s[STAT_WRAP_BIT]          = wrapped[p];
    return s;
  endfunction : status_word

  function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
    logic [1:0] g;
    logic [2:0] f;
    g = a[GRP_LSB +: 2];
    f = a[FLD_LSB +: 3];
    if (g == GRP_COMMON) begin
      return f <= C_STAT_CHROMA;
    end else if (g == GRP_LUMA || g == GRP_CHROMA) begin
      return f <= F_ELIM;
    end else begin
      return 1'b0;
    end
  endfunction : addr_ok

  function automatic logic [DATA_W-1:0] read_word(input logic [ADDR_W-1:0] a);
    logic [1:0]        g;
    logic [2:0]        f;
    logic [DATA_W-1:0] d;
    g = a[GRP_LSB +: 2];
    f = a[FLD_LSB +: 3];
    d = '0;
    if (addr_ok(a)) begin
      if (g == GRP_COMMON) begin
        case (f)
          C_CTRL:      d[CTRL_RGB_BIT] = rgb_mode;
          C_STAT_LUMA: d = status_word(0);
          default:     d = status_word(1);
        endcase
      end else begin
        // upper half stays zero, reserved bits read as zero
        d[HALF_W-1:0] = plane_reg[g == GRP_CHROMA][f];
      end
    end
    return d;
  endfunction : read_word

  // ----------------------------------------------------------------
  // bus and register next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [1:0]        g;
    logic [2:0]        f;
    logic [HALF_W-1:0] merged;
    logic              do_write;
    g        = aw_addr[GRP_LSB +: 2];
    f        = aw_addr[FLD_LSB +: 3];
    merged   = '0;
    do_write = aw_held && w_held && !s_axi_bvalid;

    next_plane_reg = plane_reg;
    next_rgb_mode  = rgb_mode;
    next_wrapped   = wrapped;
    next_aw_held   = aw_held;
    next_aw_addr   = aw_addr;
    next_w_held    = w_held;
    next_w_data    = w_data;
    next_w_strb    = w_strb;
    next_bvalid    = s_axi_bvalid;
    next_bresp     = s_axi_bresp;
    next_rvalid    = s_axi_rvalid;
    next_rdata     = s_axi_rdata;
    next_rresp     = s_axi_rresp;

    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end

    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = addr_ok(aw_addr) ? RESP_OKAY : RESP_SLVERR;
      if (addr_ok(aw_addr)) begin
        if (g == GRP_COMMON) begin
          if (f == C_CTRL && w_strb[0]) begin
            next_rgb_mode = w_data[CTRL_RGB_BIT];
          end else if (f == C_STAT_LUMA && w_strb[2]) begin
            next_wrapped[0] = wrapped[0] & ~w_data[STAT_WRAP_BIT];
          end else if (f == C_STAT_CHROMA && w_strb[2]) begin
            next_wrapped[1] = wrapped[1] & ~w_data[STAT_WRAP_BIT];
          end
        end else begin
          merged = plane_reg[g == GRP_CHROMA][f];
          if (w_strb[0]) begin
            merged[7:0] = w_data[7:0];
          end
          if (w_strb[1]) begin
            merged[15:8] = w_data[15:8];
          end
          // pitch keeps its low bits at zero, line fields keep 13 bits
          next_plane_reg[g == GRP_CHROMA][f] = merged & FIELD_MASK[f];
        end
      end
    end
    // a wrap in the clearing cycle still sets the flag
    next_wrapped = next_wrapped | wrap_pulse;

    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end

    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rdata  = read_word(s_axi_araddr);
      next_rresp  = addr_ok(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end

    next_awready = !next_aw_held;
    next_wready  = !next_w_held;
    next_arready = !next_rvalid;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int p = 0; p < PLANES; p++) begin
        for (int i = 0; i < NFIELD; i++) begin
          plane_reg[p][i] <= FIELD_RESET[i];
        end
      end
      rgb_mode      <= 1'b0;
      wrapped       <= '0;
      aw_held       <= 1'b0;
      aw_addr       <= '0;
      w_held        <= 1'b0;
      w_data        <= '0;
      w_strb        <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      plane_reg     <= next_plane_reg;
      rgb_mode      <= next_rgb_mode;
      wrapped       <= next_wrapped;
      aw_held       <= next_aw_held;
      aw_addr       <= next_aw_addr;
      w_held        <= next_w_held;
      w_data        <= next_w_data;
      w_strb        <= next_w_strb;
      s_axi_awready <= next_awready;
      s_axi_wready  <= next_wready;
      s_axi_bvalid  <= next_bvalid;
      s_axi_bresp   <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid  <= next_rvalid;
      s_axi_rdata   <= next_rdata;
      s_axi_rresp   <= next_rresp;
    end
  end

endmodule : sola_line_addresser

// file: sola_line_addresser_checker.sv
`timescale 1ns/1ps

module sola_line_addresser_checker (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        frame_start,
  input wire logic        line_done,
  input wire logic [31:0] luma_line_addr,
  input wire logic [12:0] luma_line_index,
  input wire logic [12:0] chroma_line_index
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ----------------------------------------------------------------
  // line walk
  // ----------------------------------------------------------------
  idx_step_a: assert property (
    line_done && !frame_start |=> luma_line_index == 13'h0
    || luma_line_index == $past(luma_line_index) + 13'h1) else $error("luma index bad step");
  chroma_step_a: assert property (
    line_done && !frame_start |=> chroma_line_index == 13'h0
    || chroma_line_index == $past(chroma_line_index) + 13'h1) else $error("chroma index bad step");
  idx_hold_a: assert property (
    !frame_start && !line_done |=> $stable(luma_line_index)) else $error("index moved idle");
  // a write may retarget the address, so only quiet steps are judged
  pitch_align_a: assert property (
    line_done && !frame_start && !s_axi_wvalid && !$past(s_axi_wvalid) |=>
    luma_line_index == 13'h0 || luma_line_addr[4:0] == $past(luma_line_addr[4:0]))
    else $error("line step not a 32 byte multiple");
  reset_clear_a: assert property (
    $rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && luma_line_index == 13'h0)
    else $error("outputs not clear after reset");
  // ----------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------
  wr_answer_a: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid
    |-> ##[1:2] s_axi_bvalid) else $error("write not answered");
  bresp_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  rd_answer_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read not answered");
  rdata_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  cover property (frame_start ##2 line_done);
  cover property (line_done ##1 luma_line_index == 13'h0);
  cover property (s_axi_bvalid && s_axi_bready);
endmodule : sola_line_addresser_checker

bind sola_line_addresser sola_line_addresser_checker i_chk (.*);

// file: sola_mem_port_model.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// memory controller side: paces lines, takes each line address
// ----------------------------------------------------------------
module sola_mem_port_model
  import sola_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              req,
  input  wire logic              req_frame,
  input  wire logic [3:0]        gap,
  input  wire logic [DATA_W-1:0] luma_addr,
  input  wire logic [DATA_W-1:0] chroma_addr,
  output logic                   frame_start,
  output logic                   line_done,
  output logic                   ack,
  output logic      [DATA_W-1:0] seen_luma,
  output logic      [DATA_W-1:0] seen_chroma
);
  logic [2:0] phase;
  logic [3:0] cnt;
  // one pulse per request; gap models a slow controller
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase <= 3'h0;
      cnt <= 4'h0;
      frame_start <= 1'b0;
      line_done <= 1'b0;
      ack <= 1'b0;
      seen_luma <= 32'h0;
      seen_chroma <= 32'h0;
    end else begin
      case (phase)
        3'h0: if (req) begin
          cnt <= gap;
          phase <= 3'h1;
        end
        3'h1: if (cnt == 4'h0) begin
          frame_start <= req_frame;
          line_done <= !req_frame;
          phase <= 3'h2;
        end else begin
          cnt <= cnt - 4'h1;
        end
        3'h2: begin
          frame_start <= 1'b0;
          line_done <= 1'b0;
          phase <= 3'h3;
        end
        3'h3: begin
          seen_luma <= luma_addr;
          seen_chroma <= chroma_addr;
          ack <= 1'b1;
          phase <= 3'h4;
        end
        default: begin
          ack <= 1'b0;
          if (!req) phase <= 3'h0;
        end
      endcase
    end
  end
endmodule : sola_mem_port_model

// file: sola_line_addresser_tb.sv
`timescale 1ns/1ps

module sola_line_addresser_tb
  import sola_pkg::*;
;
  localparam logic [HALF_W-1:0] RGB_P = 16'h0800;
  localparam logic [6:0]  CFG_A [10] = '{7'h28, 7'h2c, 7'h30, 7'h34, 7'h38,
                                         7'h48, 7'h4c, 7'h50, 7'h54, 7'h58};
  localparam logic [31:0] CFG_D [10] = '{32'h10, 32'h0, 32'h100, 32'h2, 32'h3,
                                         32'h20, 32'h40, 32'h40, 32'h1, 32'h3};
  logic              aclk, aresetn, frame_start, line_done, req, req_frame, ack;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata, luma_line_addr, chroma_line_addr;
  logic [DATA_W-1:0] seen_luma, seen_chroma, lst, cst;
  logic [STRB_W-1:0] s_axi_wstrb;
  logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic              s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0]        s_axi_bresp, s_axi_rresp;
  logic [LINE_W-1:0] luma_line_index, chroma_line_index;
  logic [3:0]        gap;
  logic [HALF_W-1:0] lp, cp;
  int                n_fail, checks_done, lsp, csp, llim, clim, li, ci;

  sola_line_addresser #(.RGB_PITCH(RGB_P)) i_dut (.*);
  sola_mem_port_model i_mem (.*, .luma_addr(luma_line_addr), .chroma_addr(chroma_line_addr));

  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic guard(input int n);
    if (n > 40) begin
      n_fail++;
      $display("CHECK FAILED wait expected answer seen none");
      tally_and_finish();
    end
  endtask : guard

  task automatic wr(input logic [6:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      guard(n);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
  endtask : wr

  task automatic rd(input logic [6:0] a, input logic [31:0] exp, input logic [31:0] m,
                    input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      guard(n);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk("rdata", exp, s_axi_rdata & m);
    chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
  endtask : rd

  // expected walk kept here, checked against what the controller took
  task automatic step(input logic fr, input logic [3:0] g);
    int n;
    n = 0;
    @(posedge aclk);
    req <= 1'b1;
    req_frame <= fr;
    gap <= g;
    do begin
      @(posedge aclk);
      n++;
      guard(n);
    end while (!ack);
    req <= 1'b0;
    li = fr ? lsp : ((li >= llim) ? 0 : li + 1);
    ci = fr ? csp : ((ci >= clim) ? 0 : ci + 1);
    chk("luma addr", lst + 32'(li) * {16'h0, lp}, seen_luma);
    chk("chroma addr", cst + 32'(ci) * {16'h0, cp}, seen_chroma);
    chk("luma index", 32'(li), {19'h0, luma_line_index});
    chk("chroma index", 32'(ci), {19'h0, chroma_line_index});
  endtask : step
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {req, req_frame, gap, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    {n_fail, checks_done, li, ci} = '0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 14; i++) begin
      rd(7'(32 + (i / 7) * 32 + (i % 7) * 4), (i % 7 == 6) ? 32'h1fff : 32'h0,
         32'hffffffff, RESP_OKAY);
    end
    wr(7'h30, 32'h1234, RESP_OKAY);
    rd(7'h30, 32'h1220, 32'hffffffff, RESP_OKAY);
    wr(7'h40, 32'hbeef, RESP_OKAY);
    rd(7'h40, 32'hbeef, 32'hffffffff, RESP_OKAY);
    for (int i = 0; i < 10; i++) begin
      wr(CFG_A[i], CFG_D[i], RESP_OKAY);
    end
    {lst, lp, lsp, llim} = {32'h00100000, 16'h0100, 32'd2, 32'd3};
    {cst, cp, csp, clim} = {32'h00200040, 16'h0040, 32'd1, 32'd3};
    step(1'b1, 4'h0);
    for (int i = 0; i < 6; i++) begin
      step(1'b0, 4'(3 * (i % 2)));
    end
    rd(7'h04, 32'h40000 | 32'(li), 32'h71fff, RESP_OKAY);
    rd(7'h08, 32'h40000 | 32'(ci), 32'h71fff, RESP_OKAY);
    wr(7'h04, 32'h40000, RESP_OKAY);
    rd(7'h04, 32'h0, 32'h40000, RESP_OKAY);
    wr(7'h00, 32'h1, RESP_OKAY);
    wr(7'h34, 32'h4, RESP_OKAY);
    wr(7'h38, 32'h4, RESP_OKAY);
    wr(7'h54, 32'h0, RESP_OKAY);
    wr(7'h58, 32'h4, RESP_OKAY);
    {lp, cp, lsp, llim, csp, clim} = {RGB_P, RGB_P, 32'd4, 32'd4, 32'd0, 32'd4};
    step(1'b1, 4'h2);
    for (int i = 0; i < 4; i++) begin
      step(1'b0, 4'h0);
    end
    wr(7'h00, 32'h0, RESP_OKAY);
    wr(7'h20, 32'h10, RESP_OKAY);
    rd(7'h04, 32'h10000, 32'h10000, RESP_OKAY);
    wr(7'h34, 32'h0, RESP_OKAY);
    rd(7'h04, 32'h0, 32'h10000, RESP_OKAY);
    wr(7'h1c, 32'h5, RESP_SLVERR);
    rd(7'h60, 32'h0, 32'hffffffff, RESP_SLVERR);
    tally_and_finish();
  end
endmodule : sola_line_addresser_tb
